/* File: logic/ldpr_ram.sv */
`timescale 1ns/1ps
// Summary of operation
// - array holds 589,824 bits, parity lanes included.
// - modes: true dual, simple dual, single port, fifo; no rom.
// - no preload; contents undefined after power-up.
// - every input is registered; all access is synchronous.
// - output register can be bypassed per port.
// - shapes 64Kx9, 32Kx18, 16Kx36, 8Kx72, 4Kx144 (8-bit variants alike).
// - the 144-bit shape is refused in true dual-port mode.
// - simple dual mixes 9..72 widths freely; 144 pairs only with 144.
// - true dual ports each use any of 9, 18, 36, 72 widths.
// - one write-select per port picks read or write; no read enable.
// - outside the 9-bit shape, a lane writes only with write-select and its mask bit; mask idles high.
// - lane masking applies in 18, 36 and 72-bit shapes.
// - in 144-bit mode both ports' masks join into 16 bits.
// - mask bit n gates data bits 9n to 9n+8.
// - wide mask bit 15 gates data bits 135 to 143.
// - any mask combination allowed; same lanes serve 8-bit data.
// - all input registers share the one block clock.
module ldpr_ram (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // static configuration
    input wire ldpr_pkg::ldpr_cfg_t cfg,
    // port a
    input wire ldpr_pkg::ldpr_req_t req_a,
    output logic [71:0] rdata_a,
    // port b
    input wire ldpr_pkg::ldpr_req_t req_b,
    output logic [71:0] rdata_b,
    // status
    output logic cfg_error,
    output logic fifo_full,
    output logic fifo_empty
);

    // ==================================================================
    // helpers

    // true when the shape set is a legal one for the mode
    function automatic logic cfg_legal(input ldpr_pkg::ldpr_cfg_t c);
        logic wide_a;
        logic wide_b;
        wide_a = (c.width_a == ldpr_pkg::LDPR_W144);
        wide_b = (c.width_b == ldpr_pkg::LDPR_W144);
        if (c.width_a > ldpr_pkg::LDPR_W144 || c.width_b > ldpr_pkg::LDPR_W144) begin
            cfg_legal = 1'b0;
        end else if (c.mode == ldpr_pkg::LDPR_SIMPLE_DUAL) begin
            cfg_legal = (wide_a == wide_b);
        end else if (c.mode == ldpr_pkg::LDPR_TRUE_DUAL) begin
            cfg_legal = !wide_a && !wide_b;
        end else begin
            cfg_legal = !wide_a;
        end
    endfunction : cfg_legal

    // lane index of lane i of the word at addr in the given shape
    function automatic logic [15:0] lane_index(input logic [15:0] addr,
                                               input ldpr_pkg::ldpr_width_t w,
                                               input int i);
        logic [15:0] base;
        base = addr << w;
        lane_index = base + 16'(i);
    endfunction : lane_index

    // number of lanes in a word of the given shape
    function automatic int lane_count(input ldpr_pkg::ldpr_width_t w);
        lane_count = 1 << w;
    endfunction : lane_count

    // ==================================================================
    // input registers, all on the one clock

    ldpr_pkg::ldpr_cfg_t cfg_q;
    ldpr_pkg::ldpr_req_t req_a_q;
    ldpr_pkg::ldpr_req_t req_b_q;

    // capture every input before use
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_q <= '0;
            req_a_q <= '0;
            req_b_q <= '0;
        end else begin
            cfg_q <= cfg;
            req_a_q <= req_a;
            req_b_q <= req_b;
        end
    end

    // ==================================================================
    // storage: 9-bit lanes, never reset, never preloaded

    logic [8:0] lanes [0:ldpr_pkg::LANE_COUNT-1];

    // ==================================================================
    // fifo pointers

    logic [15:0] wr_ptr;
    logic [15:0] rd_ptr;
    logic [16:0] fill;
    logic [16:0] fifo_depth;
    logic [15:0] ptr_mask;
    logic push;
    logic pop;
    logic legal;

    // ==================================================================
    // effective operation of each port

    logic we_a;
    logic we_b;
    logic [15:0] addr_a;
    logic [15:0] addr_b;
    logic wide;
    logic [143:0] wdata_wide;
    logic [15:0] mask_wide;
    logic [15:0] mask_eff_a;
    logic [7:0] mask_eff_b;
    logic [143:0] rd_a;
    logic [143:0] rd_b;
    logic [143:0] lat_a;
    logic [143:0] lat_b;

    // legality, fifo depth and control decode
    always_comb begin
        legal = cfg_legal(cfg_q);
        wide = (cfg_q.width_a == ldpr_pkg::LDPR_W144);
        fifo_depth = 17'(ldpr_pkg::LANE_COUNT) >> cfg_q.width_a;
        ptr_mask = 16'(fifo_depth - 17'h1);
        // write-select of port b is the pop request in fifo mode
        push = req_a_q.wr && (fill != fifo_depth);
        pop = req_b_q.wr && (fill != ldpr_pkg::RST_COUNT);
        we_a = 1'b0;
        we_b = 1'b0;
        addr_a = req_a_q.addr;
        addr_b = req_b_q.addr;
        case (cfg_q.mode)
            ldpr_pkg::LDPR_TRUE_DUAL: begin
                we_a = req_a_q.wr;
                we_b = req_b_q.wr;
            end
            ldpr_pkg::LDPR_SIMPLE_DUAL: begin
                we_a = req_a_q.wr;
            end
            ldpr_pkg::LDPR_SINGLE: begin
                we_a = req_a_q.wr;
            end
            ldpr_pkg::LDPR_FIFO: begin
                we_a = push;
                addr_a = wr_ptr;
                addr_b = rd_ptr;
            end
            default: begin
                we_a = 1'b0;
            end
        endcase
        if (!legal) begin
            we_a = 1'b0;
            we_b = 1'b0;
        end
        // wide word joins both ports' data and masks
        wdata_wide = {req_b_q.wdata, req_a_q.wdata};
        mask_wide = {req_b_q.mask, req_a_q.mask};
        // the 9-bit shape has no masking
        if (cfg_q.width_a == ldpr_pkg::LDPR_W9) begin
            mask_eff_a = 16'hffff;
        end else if (wide) begin
            mask_eff_a = mask_wide;
        end else begin
            mask_eff_a = {8'h00, req_a_q.mask};
        end
        if (cfg_q.width_b == ldpr_pkg::LDPR_W9) begin
            mask_eff_b = 8'hff;
        end else begin
            mask_eff_b = req_b_q.mask;
        end
    end

    // array read for both ports, unused lanes read as zero
    always_comb begin
        rd_a = '0;
        rd_b = '0;
        for (int i = 0; i < ldpr_pkg::WIDE_LANES; i++) begin
            if (i < lane_count(cfg_q.width_a)) begin
                rd_a[9*i +: 9] = lanes[lane_index(addr_a, cfg_q.width_a, i)];
            end
            if (i < lane_count(cfg_q.width_b)) begin
                rd_b[9*i +: 9] = lanes[lane_index(addr_b, cfg_q.width_b, i)];
            end
        end
    end

    // ==================================================================
    // array writes; a lane with a clear mask bit is left alone

    always_ff @(posedge clock) begin
        for (int i = 0; i < ldpr_pkg::WIDE_LANES; i++) begin
            if (we_a && i < lane_count(cfg_q.width_a) && mask_eff_a[i]) begin
                lanes[lane_index(addr_a, cfg_q.width_a, i)] <= wdata_wide[9*i +: 9];
            end
        end
        for (int i = 0; i < ldpr_pkg::PORT_LANES; i++) begin
            if (we_b && i < lane_count(cfg_q.width_b) && mask_eff_b[i]) begin
                lanes[lane_index(addr_b, cfg_q.width_b, i)] <= req_b_q.wdata[9*i +: 9];
            end
        end
    end

    // ==================================================================
    // fifo pointer and fill tracking

    always_ff @(posedge clock) begin
        if (rst || cfg_q.mode != ldpr_pkg::LDPR_FIFO || !legal) begin
            wr_ptr <= ldpr_pkg::RST_PTR;
            rd_ptr <= ldpr_pkg::RST_PTR;
            fill <= ldpr_pkg::RST_COUNT;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr + 16'h1) & ptr_mask;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr + 16'h1) & ptr_mask;
            end
            if (push && !pop) begin
                fill <= fill + 17'h1;
            end else if (pop && !push) begin
                fill <= fill - 17'h1;
            end
        end
    end

    // fifo status flags
    always_ff @(posedge clock) begin
        if (rst) begin
            fifo_full <= 1'b0;
            fifo_empty <= 1'b1;
        end else if (cfg_q.mode != ldpr_pkg::LDPR_FIFO || !legal) begin
            fifo_full <= 1'b0;
            fifo_empty <= 1'b1;
        end else begin
            fifo_full <= (fill == fifo_depth) || (push && !pop && fill + 17'h1 == fifo_depth);
            fifo_empty <= (fill == 17'h0 && !push) || (pop && !push && fill == 17'h1);
        end
    end

    // configuration error flag
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_error <= 1'b0;
        end else begin
            cfg_error <= !legal;
        end
    end

    // ==================================================================
    // read data: optional output register stage

    // registered path holds the array read one more cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            lat_a <= '0;
            lat_b <= '0;
        end else begin
            lat_a <= rd_a;
            lat_b <= rd_b;
        end
    end

    // port a output; in simple dual mode port a only writes, and in 144-bit mode carries the wide word's lower half
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_a <= ldpr_pkg::RST_RDATA;
        end else if (cfg_q.mode == ldpr_pkg::LDPR_SIMPLE_DUAL && wide) begin
            rdata_a <= cfg_q.bypass_b ? rd_b[71:0] : lat_b[71:0];
        end else if (cfg_q.mode == ldpr_pkg::LDPR_SIMPLE_DUAL ||
                     cfg_q.mode == ldpr_pkg::LDPR_FIFO) begin
            rdata_a <= ldpr_pkg::RST_RDATA;
        end else begin
            rdata_a <= cfg_q.bypass_a ? rd_a[71:0] : lat_a[71:0];
        end
    end

    // port b output; upper half of the wide word in 144-bit mode
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_b <= ldpr_pkg::RST_RDATA;
        end else if (cfg_q.mode == ldpr_pkg::LDPR_SINGLE) begin
            rdata_b <= ldpr_pkg::RST_RDATA;
        end else if (wide) begin
            rdata_b <= cfg_q.bypass_b ? rd_b[143:72] : lat_b[143:72];
        end else begin
            rdata_b <= cfg_q.bypass_b ? rd_b[71:0] : lat_b[71:0];
        end
    end

endmodule : ldpr_ram

/* File: logic/ldpr_pkg.sv */
// ==================================================================
// shared constants and types of the large dual-port memory block
package ldpr_pkg;

    // ==================================================================
    // storage geometry
    localparam int LANE_BITS = 9;             // one data lane: 8 data + 1 parity
    localparam int LANE_ADDR_W = 16;          // lane index width
    localparam int LANE_COUNT = 65536;        // lanes in the array
    localparam int TOTAL_BITS = 589824;       // lanes times lane width
    localparam int PORT_LANES = 8;            // lanes carried by one port's pins
    localparam int WIDE_LANES = 16;           // lanes of the widest word
    localparam int PORT_DATA_W = 72;          // data pins per port
    localparam int WIDE_DATA_W = 144;         // widest word
    localparam int FIFO_CNT_W = 17;           // fifo fill counter width

    // ==================================================================
    // values after reset
    localparam logic [71:0] RST_RDATA = 72'h0;
    localparam logic [15:0] RST_PTR = 16'h0;
    localparam logic [16:0] RST_COUNT = 17'h0;

    // ==================================================================
    // operating modes
    typedef enum logic [1:0] {
        LDPR_TRUE_DUAL = 2'b00,
        LDPR_SIMPLE_DUAL = 2'b01,
        LDPR_SINGLE = 2'b10,
        LDPR_FIFO = 2'b11
    } ldpr_mode_t;

    // port shapes: code n means 2**n lanes per word
    typedef enum logic [2:0] {
        LDPR_W9 = 3'b000,
        LDPR_W18 = 3'b001,
        LDPR_W36 = 3'b010,
        LDPR_W72 = 3'b011,
        LDPR_W144 = 3'b100
    } ldpr_width_t;

    // one port's request as seen at its pins
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic [7:0] mask;
        logic [71:0] wdata;
    } ldpr_req_t;

    // static configuration
    typedef struct packed {
        ldpr_mode_t mode;
        ldpr_width_t width_a;
        ldpr_width_t width_b;
        logic bypass_a;
        logic bypass_b;
    } ldpr_cfg_t;

endpackage : ldpr_pkg

/* File: tb/ldpr_ram_assertions.sv */
`timescale 1ns/1ps
// ==================================================================
// port checks of the memory block
module ldpr_ram_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // configuration and requests
    input wire ldpr_pkg::ldpr_cfg_t cfg,
    input wire ldpr_pkg::ldpr_req_t req_a,
    input wire ldpr_pkg::ldpr_req_t req_b,
    // results
    input wire logic [71:0] rdata_a,
    input wire logic [71:0] rdata_b,
    input wire logic cfg_error,
    input wire logic fifo_full,
    input wire logic fifo_empty
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // mode decodes
    wire logic fifo = cfg.mode == ldpr_pkg::LDPR_FIFO;
    wire logic wide = cfg.width_a == ldpr_pkg::LDPR_W144 || cfg.width_b == ldpr_pkg::LDPR_W144;
    wire logic idle = !rst && !req_a.wr && !req_b.wr;
    // reset, config and mode relations; cfg needs two edges to reach the flags
    property p_rst;
        disable iff (1'b0) rst |=> rdata_a == 72'h0 && rdata_b == 72'h0 && !cfg_error
            && fifo_empty && !fifo_full;
    endproperty
    property p_no_fifo;
        !fifo [*3] |-> fifo_empty && !fifo_full;
    endproperty
    property p_bad;
        (cfg.mode == ldpr_pkg::LDPR_TRUE_DUAL && wide) [*3] |-> cfg_error;
    endproperty
    property p_single_b;
        (cfg.mode == ldpr_pkg::LDPR_SINGLE) [*5] |-> rdata_b == 72'h0;
    endproperty
    property p_simple_a;
        (cfg.mode == ldpr_pkg::LDPR_SIMPLE_DUAL && !wide) [*5] |-> rdata_a == 72'h0;
    endproperty
    // read data follows only the registered request
    property p_steady;
        (idle && $stable(req_a) && $stable(req_b) && $stable(cfg)) [*5]
            |-> rdata_a === $past(rdata_a);
    endproperty
    // fifo empty flag falls only with pushes
    property p_fifo_hold;
        (fifo && fifo_empty && !req_a.wr) [*4] |=> fifo_empty;
    endproperty
    property p_fifo_push;
        fifo && !wide && $stable(cfg) && fifo_empty && req_a.wr |-> ##[1:3] !fifo_empty;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    a_no_fifo: assert property (p_no_fifo) else $error("fifo flags outside fifo");
    a_bad: assert property (p_bad) else $error("wide true dual not refused");
    a_single_b: assert property (p_single_b) else $error("port b live in single");
    a_simple_a: assert property (p_simple_a) else $error("port a reads in simple");
    a_steady: assert property (p_steady) else $error("read data moved");
    a_fifo_hold: assert property (p_fifo_hold) else $error("empty fell alone");
    a_fifo_push: assert property (p_fifo_push) else $error("push not seen");
    // main scenarios reached
    c_bad: cover property (cfg_error);
    c_push: cover property (fifo && req_a.wr);
    c_mask: cover property (req_b.wr && req_b.mask != 8'hff);
endmodule : ldpr_ram_chk

bind ldpr_ram ldpr_ram_chk chk_u (.clock(clock), .rst(rst), .cfg(cfg), .req_a(req_a),
    .req_b(req_b), .rdata_a(rdata_a), .rdata_b(rdata_b), .cfg_error(cfg_error),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty));

/* File: tb/ldpr_user.sv */
`timescale 1ns/1ps
// ==================================================================
// fabric user logic: one request per port per cycle
module ldpr_user (
    // clock
    input wire logic clock,
    // requests to the block
    output ldpr_pkg::ldpr_req_t req_a,
    output ldpr_pkg::ldpr_req_t req_b
);
    // idle reads with the mask at its all-ones tie-off
    initial begin
        req_a = {16'h0, 1'b0, 8'hff, 72'h0};
        req_b = {16'h0, 1'b0, 8'hff, 72'h0};
    end
    // present a request pair just after an edge
    task automatic issue(input ldpr_pkg::ldpr_req_t a, input ldpr_pkg::ldpr_req_t b);
        @(posedge clock);
        req_a <= a;
        req_b <= b;
    endtask : issue
    // drop write-select; unused data flips so stale values never look valid
    task automatic release_all();
        @(posedge clock);
        req_a <= {req_a.addr, 1'b0, 8'hff, ~req_a.wdata};
        req_b <= {req_b.addr, 1'b0, 8'hff, ~req_b.wdata};
    endtask : release_all
endmodule : ldpr_user

/* File: tb/ldpr_ram_bench.sv */
`timescale 1ns/1ps
// ==================================================================
// self-checking bench of the memory block
module ldpr_ram_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    ldpr_pkg::ldpr_cfg_t cfg = 11'h0db;
    ldpr_pkg::ldpr_req_t req_a, req_b, nop;
    logic [71:0] rdata_a, rdata_b, got, m1;
    logic cfg_error, fifo_full, fifo_empty;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [71:0] d0 = 72'h0123456789abcdef01;
    localparam logic [71:0] d1 = 72'hfedcba9876543210fe;
    // 25 ns clock
    always #12.5 clock = ~clock;
    ldpr_ram dut_u (.clock(clock), .rst(rst), .cfg(cfg), .req_a(req_a), .rdata_a(rdata_a),
        .req_b(req_b), .rdata_b(rdata_b), .cfg_error(cfg_error), .fifo_full(fifo_full),
        .fifo_empty(fifo_empty));
    ldpr_user user_u (.clock(clock), .req_a(req_a), .req_b(req_b));
    // ==================================================================
    // helpers
    task automatic chk_data(input logic [71:0] g, input logic [71:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_data
    task automatic chk_flag(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_flag
    // merge new lanes into old where the mask is set
    function automatic logic [71:0] mix(input logic [71:0] o, n, input logic [7:0] m);
        for (int i = 0; i < 8; i++) begin
            if (m[i]) o[9*i+:9] = n[9*i+:9];
        end
        return o;
    endfunction : mix
    function automatic ldpr_pkg::ldpr_req_t rq(input logic [15:0] a, input logic w,
        input logic [7:0] m, input logic [71:0] d);
        return {a, w, m, d};
    endfunction : rq
    // mode, widths, shared bypass; three edges settle the registered config
    task automatic set_cfg(input logic [1:0] md, input logic [2:0] wa, wb, input logic bp);
        @(posedge clock);
        cfg <= {md, wa, wb, bp, bp};
        repeat (3) @(posedge clock);
        #1;
    endtask : set_cfg
    task automatic wr2(input ldpr_pkg::ldpr_req_t a, input ldpr_pkg::ldpr_req_t b);
        user_u.issue(a, b);
        user_u.release_all();
    endtask : wr2
    // read one port; data one edge later when bypassed, two otherwise
    task automatic rd(input logic pb, input logic [15:0] a);
        ldpr_pkg::ldpr_req_t r;
        r = rq(a, 1'b0, 8'hff, 72'h0);
        user_u.issue(pb ? nop : r, pb ? r : nop);
        user_u.release_all();
        @(posedge clock);
        if (!(pb ? cfg.bypass_b : cfg.bypass_a)) @(posedge clock);
        #1;
        got = pb ? rdata_b : rdata_a;
    endtask : rd
    // ==================================================================
    // scenarios
    task automatic t_reset();
        chk_data(rdata_a, 72'h0);
        chk_flag(cfg_error, 1'b0);
        chk_flag(fifo_empty, 1'b1);
        $display("reset test done");
    endtask : t_reset
    task automatic t_lanes();
        set_cfg(2'h0, 3'h3, 3'h3, 1'b1);
        m1 = mix(d0, d1, 8'h81);
        wr2(rq(16'h5, 1'b1, 8'hff, d0), nop);
        wr2(nop, rq(16'h5, 1'b1, 8'h81, d1));
        rd(1'b1, 16'h5);
        chk_data(got, m1);
        rd(1'b0, 16'h5);
        chk_data(got, m1);
        repeat (6) @(posedge clock);
        $display("lane mask test done");
    endtask : t_lanes
    task automatic t_mixed();
        set_cfg(2'h1, 3'h0, 3'h0, 1'b0);
        wr2(rq(16'h28, 1'b1, 8'h00, 72'h1a5), nop);
        rd(1'b1, 16'h28);
        chk_data({63'h0, got[8:0]}, 72'h1a5);
        rd(1'b1, 16'h2f);
        chk_data({63'h0, got[8:0]}, {63'h0, m1[71:63]});
        $display("mixed width test done");
    endtask : t_mixed
    task automatic t_wide();
        set_cfg(2'h1, 3'h4, 3'h4, 1'b1);
        wr2(rq(16'h3, 1'b1, 8'hff, d0), rq(16'h3, 1'b0, 8'hff, d1));
        wr2(rq(16'h3, 1'b1, 8'h01, ~d0), rq(16'h0, 1'b0, 8'h80, ~d1));
        rd(1'b1, 16'h3);
        chk_data(got, mix(d1, ~d1, 8'h80));
        chk_data(rdata_a, mix(d0, ~d0, 8'h01));
        $display("wide test done");
    endtask : t_wide
    task automatic t_bad();
        set_cfg(2'h0, 3'h4, 3'h3, 1'b1);
        chk_flag(cfg_error, 1'b1);
        wr2(rq(16'h5, 1'b1, 8'hff, d1), nop);
        set_cfg(2'h0, 3'h3, 3'h3, 1'b1);
        chk_flag(cfg_error, 1'b0);
        rd(1'b0, 16'h5);
        chk_data(got, {m1[71:9], 9'h1a5});
        $display("refused shape test done");
    endtask : t_bad
    task automatic t_single();
        set_cfg(2'h2, 3'h3, 3'h3, 1'b0);
        wr2(rq(16'h9, 1'b1, 8'hff, d1), nop);
        rd(1'b0, 16'h9);
        chk_data(got, d1);
        chk_data(rdata_b, 72'h0);
        $display("single port test done");
    endtask : t_single
    task automatic t_fifo();
        set_cfg(2'h3, 3'h3, 3'h3, 1'b1);
        chk_flag(fifo_empty, 1'b1);
        wr2(rq(16'h0, 1'b1, 8'hff, d0), nop);
        wr2(rq(16'h0, 1'b1, 8'hff, d1), nop);
        repeat (3) @(posedge clock);
        #1;
        chk_flag(fifo_empty, 1'b0);
        chk_flag(fifo_full, 1'b0);
        chk_data(rdata_b, d0);
        wr2(nop, rq(16'h0, 1'b1, 8'hff, 72'h0));
        repeat (3) @(posedge clock);
        #1;
        chk_data(rdata_b, d1);
        wr2(nop, rq(16'h0, 1'b1, 8'hff, 72'h0));
        repeat (3) @(posedge clock);
        #1;
        chk_flag(fifo_empty, 1'b1);
        $display("fifo test done");
    endtask : t_fifo
    // ==================================================================
    // verdict
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            summarize();
        end
    end
    // main sequence
    initial begin
        nop = rq(16'h0, 1'b0, 8'hff, 72'h0);
        repeat (5) @(posedge clock);
        #1;
        t_reset();
        @(posedge clock);
        rst <= 1'b0;
        t_lanes();
        t_mixed();
        t_wide();
        t_bad();
        t_single();
        t_fifo();
        summarize();
    end
endmodule : ldpr_ram_bench
